// >>> core/aesb_top.sv
// single-block aes encryptor with dma fetch and writeback and shared-core arbitration
`timescale 1ns/1ps
`include "aesb_defines.svh"
// Contract
// [R1] encrypt one 128-bit block, aes-128, encrypt only
// [R2] start task fetches key, cleartext by dma
// [R3] done event only after ciphertext fully written
// [R4] abort task stops a running encryption
// [R5] higher core user claiming aborts with error
// [R6] dma reaches data ram only
// [R7] software keeps pointer inside data ram
// [R8] dma finished when done or error raised; a start refused mid-block raises error before that block's dma ends
// [R9] inputs and output share one structure
// [R10] key at 0, cleartext 16, ciphertext 32
// [R11] software loads pointer before start task
// [R12] start while core busy: error, no start
// [R13] aborted running encryption raises error event
// [R14] one block within 7.2 microseconds
// [R15] enable set/clear by ones, read state
// [R16] irq while enabled flag set; sticky flags
// [R17] arbitrate core before fetch, release after
module aesb_top import aesb_pkg::*; #(
   parameter logic [31:0] RAM_BASE    = 32'h2000_0000,
   parameter logic [31:0] RAM_BYTES   = 32'h0000_8000,
   parameter int          TIMEOUT_CYC = `AESB_BLOCK_CYC
) (
   input  wire logic        CLOCK,
   input  wire logic        RESETN,
   input  wire logic [11:0] REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WRITE,
   input  wire logic        REG_READ,
   output logic      [31:0] REG_RDATA,
   output logic             IRQ,
   output logic             DMA_REQ,
   output logic             DMA_WE,
   output logic      [31:0] DMA_ADDR,
   output logic      [31:0] DMA_WDATA,
   input  wire logic [31:0] DMA_RDATA,
   input  wire logic        DMA_ACK,
   input  wire logic        CCM_CLAIM,
   input  wire logic        RESOLVER_CLAIM,
   output logic             CCM_GRANT,
   output logic             RESOLVER_GRANT
);
   localparam int CW = $clog2(TIMEOUT_CYC + 1);
   localparam logic [CW-1:0] TMO_LAST = CW'(TIMEOUT_CYC - 1);

   // refuse settings the sequencer cannot serve
   if (RAM_BYTES < `AESB_STRUCT_BYTES || RAM_BASE[1:0] != 2'h0 || TIMEOUT_CYC < `AESB_MIN_CYC) begin : g_check
      $error("aesb_top: ram window or timeout unusable");
   end

   aesb_state_t   state;
   logic          done_flag;
   logic          err_flag;
   logic [1:0]    irq_en;
   logic [31:0]   ptr;
   logic [31:0]   ptr_run;
   logic [2:0]    wcnt;
   logic [CW-1:0] run_cnt;
   logic          ecb_grant;
   logic          other_busy;
   logic          preempt;

   // sequencer owns a block: fetch, cipher or store
   wire running = state == ST_FETCH || state == ST_CRYPT || state == ST_STORE;

   aesb_core_if cif ();

   aesb_cipher u_cipher (
      .clock  (CLOCK),
      .resetn (RESETN),
      .core   (cif.engine)
   );

   aesb_arbiter u_arbiter (
      .clock          (CLOCK),
      .resetn         (RESETN),
      .ecb_req        (running),
      .ccm_claim      (CCM_CLAIM),
      .resolver_claim (RESOLVER_CLAIM),
      .ccm_grant      (CCM_GRANT),
      .resolver_grant (RESOLVER_GRANT),
      .ecb_grant      (ecb_grant),
      .other_busy     (other_busy),
      .preempt        (preempt)
   );

   // register write decode
   wire wr_start  = REG_WRITE && REG_ADDR == `AESB_OFS_START && REG_WDATA[0];
   wire wr_stop   = REG_WRITE && REG_ADDR == `AESB_OFS_ABORT && REG_WDATA[0];
   wire wr_done   = REG_WRITE && REG_ADDR == `AESB_OFS_DONE;
   wire wr_err    = REG_WRITE && REG_ADDR == `AESB_OFS_ERROR;
   wire wr_ienset = REG_WRITE && REG_ADDR == `AESB_OFS_IENSET;
   wire wr_ienclr = REG_WRITE && REG_ADDR == `AESB_OFS_IENCLR;
   wire wr_ptr    = REG_WRITE && REG_ADDR == `AESB_OFS_PTR;

   // pointer must leave the whole structure inside data ram
   wire [32:0] ptr_end = {1'b0, ptr} + {1'b0, `AESB_STRUCT_BYTES};
   wire [32:0] ram_end = {1'b0, RAM_BASE} + {1'b0, RAM_BYTES};
   wire        ptr_ok  = ptr >= RAM_BASE && ptr_end <= ram_end && ptr[1:0] == 2'h0; // [R6] [R7]

   // sequencer conditions
   wire ack        = DMA_REQ && DMA_ACK;
   wire timeout    = running && run_cnt == TMO_LAST; // [R14]
   wire kill       = running && (wr_stop || preempt || timeout); // [R4] [R5]
   wire start_ok   = wr_start && state == ST_IDLE && !other_busy && ptr_ok;
   wire start_bad  = wr_start && !start_ok; // [R12]
   wire fetch_last = state == ST_FETCH && ack && wcnt == `AESB_FETCH_LAST;
   wire store_last = state == ST_STORE && ack && wcnt == `AESB_STORE_LAST;
   wire drain_wait = DMA_REQ && !DMA_ACK;
   wire err_end    = (kill && !drain_wait) || (state == ST_DRAIN && DMA_ACK); // [R8] [R13]
   wire done_set   = store_last && !kill; // [R3]
   wire err_set    = start_bad || err_end;

   // next dma word: fetch key then cleartext, store ciphertext
   wire        issue     = !DMA_REQ && ecb_grant && !kill && (state == ST_FETCH || state == ST_STORE); // [R17]
   wire [31:0] part_ofs  = wcnt[2] ? `AESB_CLEAR_OFS : `AESB_KEY_OFS;
   wire [31:0] fetch_adr = ptr_run + part_ofs + {28'h0, wcnt[1:0], 2'h0}; // [R10]
   wire [31:0] store_adr = ptr_run + `AESB_CIPHER_OFS + {28'h0, wcnt[1:0], 2'h0}; // [R9] [R10]
   wire [6:0]  res_shift = `AESB_RES_TOP_SHIFT - {wcnt[1:0], 5'h00};
   wire [127:0] res_down = cif.result >> res_shift;
   wire [31:0] store_dat = {res_down[7:0], res_down[15:8], res_down[23:16], res_down[31:24]};
   wire        next_req  = issue ? 1'b1 : (ack ? 1'b0 : DMA_REQ);

   // words of the engine arrive straight from the read answers
   assign cif.load  = state == ST_FETCH && ack; // [R2]
   assign cif.word  = DMA_RDATA;
   assign cif.abort = kill; // [R4] [R5]

   // flags: a hardware set wins over a software write
   wire       next_done = done_set || (wr_done ? REG_WDATA[0] : done_flag); // [R16]
   wire       next_err  = err_set || (wr_err ? REG_WDATA[0] : err_flag); // [R16]
   wire [1:0] next_en   = (irq_en | (wr_ienset ? REG_WDATA[1:0] : 2'h0))
                          & ~(wr_ienclr ? REG_WDATA[1:0] : 2'h0); // [R15]
   wire [1:0] next_flag = {next_err, next_done};

   // read mux, unmapped and write-only offsets read zero
   wire [31:0] rd_mux =
      (REG_ADDR == `AESB_OFS_DONE)   ? {31'h0, done_flag} :
      (REG_ADDR == `AESB_OFS_ERROR)  ? {31'h0, err_flag} :
      (REG_ADDR == `AESB_OFS_IENSET) ? {30'h0, irq_en} :
      (REG_ADDR == `AESB_OFS_IENCLR) ? {30'h0, irq_en} :
      (REG_ADDR == `AESB_OFS_PTR)    ? ptr : 32'h0;

   // sequencer
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         state <= ST_IDLE;
      end else if (kill) begin
         state <= drain_wait ? ST_DRAIN : ST_IDLE; // [R8]
      end else begin
         unique case (state)
            ST_IDLE:  if (start_ok) state <= ST_FETCH; // [R2]
            ST_FETCH: if (fetch_last) state <= ST_CRYPT;
            ST_CRYPT: if (cif.done) state <= ST_STORE;
            ST_STORE: if (store_last) state <= ST_IDLE; // [R17]
            ST_DRAIN: if (DMA_ACK) state <= ST_IDLE;
         endcase
      end
   end

   // word counter and run-time counter
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         wcnt    <= '0;
         run_cnt <= '0;
      end else begin
         wcnt    <= (kill || store_last || start_ok) ? 3'h0 : (ack ? wcnt + 3'h1 : wcnt);
         run_cnt <= start_ok ? '0 : (running ? run_cnt + 1'b1 : run_cnt);
      end
   end

   // dma master, request held until acknowledged
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         DMA_REQ   <= 1'b0;
         DMA_WE    <= 1'b0;
         DMA_ADDR  <= '0;
         DMA_WDATA <= '0;
      end else begin
         DMA_REQ <= next_req;
         if (issue) begin
            DMA_WE    <= state == ST_STORE;
            DMA_ADDR  <= (state == ST_STORE) ? store_adr : fetch_adr;
            DMA_WDATA <= (state == ST_STORE) ? store_dat : 32'h0;
         end
      end
   end

   // software registers and interrupt line
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         done_flag <= 1'b0;
         err_flag  <= 1'b0;
         irq_en    <= 2'h0;
         ptr       <= '0;
         ptr_run   <= '0;
         IRQ       <= 1'b0;
         REG_RDATA <= '0;
      end else begin
         done_flag <= next_done;
         err_flag  <= next_err;
         irq_en    <= next_en;
         IRQ       <= |(next_flag & next_en); // [R16]
         REG_RDATA <= REG_READ ? rd_mux : 32'h0;
         if (wr_ptr) ptr <= REG_WDATA;
         if (start_ok) ptr_run <= ptr;
      end
   end

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESETN);

   sequence s_last_write;
      state == ST_STORE && DMA_WE && ack && DMA_ADDR == ptr_run + `AESB_LAST_WORD_OFS;
   endsequence
   property p_done_after_write;
      $rose(done_flag) && !$past(wr_done) |-> $past(DMA_WE && ack && DMA_ADDR == ptr_run + `AESB_LAST_WORD_OFS);
   endproperty
   a_done_after_write: assert property (p_done_after_write) else $error("done without final write"); // [R3]
   property p_store_to_done;
      s_last_write ##0 !kill |=> done_flag && state == ST_IDLE && !DMA_REQ;
   endproperty
   a_store_to_done: assert property (p_store_to_done) else $error("last write did not end the block"); // [R3]
   property p_quiet_at_event;
      (done_set || err_end) |=> !DMA_REQ;
   endproperty
   a_quiet_at_event: assert property (p_quiet_at_event) else $error("dma busy at end event"); // [R8]
   property p_abort;
      wr_stop && running && !DMA_REQ |=> err_flag && state == ST_IDLE && !cif.busy;
   endproperty
   a_abort: assert property (p_abort) else $error("abort task did not stop with error"); // [R4] [R13]
   property p_preempt;
      preempt && running && ack |=> err_flag && state == ST_IDLE;
   endproperty
   a_preempt: assert property (p_preempt) else $error("higher user did not abort the block"); // [R5]
   property p_busy_start;
      wr_start && state == ST_IDLE && other_busy |=> state == ST_IDLE && err_flag;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("start accepted while core busy"); // [R12]
   property p_ram_only;
      DMA_REQ |-> DMA_ADDR >= RAM_BASE && {1'b0, DMA_ADDR} + 33'h4 <= ram_end;
   endproperty
   a_ram_only: assert property (p_ram_only) else $error("dma address outside data ram"); // [R6]
   property p_layout;
      DMA_REQ |-> (DMA_WE ? (DMA_ADDR - ptr_run >= `AESB_CIPHER_OFS && DMA_ADDR - ptr_run < `AESB_STRUCT_BYTES)
                          : (DMA_ADDR - ptr_run < `AESB_CIPHER_OFS));
   endproperty
   a_layout: assert property (p_layout) else $error("dma access outside its structure field"); // [R9] [R10]
   property p_grant_first;
      $rose(DMA_REQ) |-> ecb_grant && $past(ecb_grant);
   endproperty
   a_grant_first: assert property (p_grant_first) else $error("dma started without the core"); // [R17]
   property p_fetch_first;
      $rose(cif.busy) |-> $past(state == ST_FETCH && ack && wcnt == `AESB_FETCH_LAST);
   endproperty
   a_fetch_first: assert property (p_fetch_first) else $error("cipher ran before fetch ended"); // [R2]
   property p_block_time;
      running |-> run_cnt < TMO_LAST + 1'b1;
   endproperty
   a_block_time: assert property (p_block_time) else $error("block ran past its time"); // [R14]
   property p_enable_set;
      wr_ienset && !wr_ienclr && REG_WDATA[`AESB_IRQ_ERR] |=> irq_en[`AESB_IRQ_ERR] ##1 IRQ == |({err_flag, done_flag} & irq_en);
   endproperty
   a_enable_set: assert property (p_enable_set) else $error("enable set or irq wrong"); // [R15] [R16]
endmodule : aesb_top

// >>> core/aesb_defines.svh
// register offsets, data-structure layout and timing constants of the block encryptor
`ifndef AESB_DEFINES_SVH
`define AESB_DEFINES_SVH
`define AESB_OFS_START       12'h000
`define AESB_OFS_ABORT       12'h004
`define AESB_OFS_DONE        12'h100
`define AESB_OFS_ERROR       12'h104
`define AESB_OFS_IENSET      12'h304
`define AESB_OFS_IENCLR      12'h308
`define AESB_OFS_PTR         12'h504
`define AESB_KEY_OFS         32'h0000_0000
`define AESB_CLEAR_OFS       32'h0000_0010
`define AESB_CIPHER_OFS      32'h0000_0020
`define AESB_LAST_WORD_OFS   32'h0000_002c
`define AESB_STRUCT_BYTES    32'h0000_0030
`define AESB_FETCH_LAST      3'h7
`define AESB_STORE_LAST      3'h3
`define AESB_RES_TOP_SHIFT   7'h60
`define AESB_IRQ_DONE        0
`define AESB_IRQ_ERR         1
`define AESB_ROUNDS          4'ha
`define AESB_ROUND_FIRST     4'h1
`define AESB_RCON_INIT       8'h01
`define AESB_GF_POLY         8'h1b
`define AESB_SBOX_AFF        8'h63
`define AESB_CLK_PS          25000
`define AESB_BLOCK_TIME_US10 72
`define AESB_BLOCK_CYC       ((`AESB_BLOCK_TIME_US10 * 100000) / `AESB_CLK_PS)
`define AESB_MIN_CYC         40
`endif

// >>> core/aesb_pkg.sv
// types shared by the block encryptor modules
package aesb_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_CRYPT, ST_STORE, ST_DRAIN} aesb_state_t;
   typedef enum logic [0:0] {CS_LOAD, CS_RUN} aesb_cstate_t;
endpackage : aesb_pkg

// >>> core/aesb_core_if.sv
// link between the controller and the aes engine
`timescale 1ns/1ps
interface aesb_core_if;
   logic         load;
   logic [31:0]  word;
   logic         abort;
   logic         done;
   logic         busy;
   logic [127:0] result;
   modport ctrl   (output load, word, abort, input done, busy, result);
   modport engine (input load, word, abort, output done, busy, result);
endinterface : aesb_core_if

// >>> core/aesb_arbiter.sv
// fixed-priority owner of the shared aes core
`timescale 1ns/1ps
module aesb_arbiter (
   input  wire logic clock,
   input  wire logic resetn,
   input  wire logic ecb_req,
   input  wire logic ccm_claim,
   input  wire logic resolver_claim,
   output logic      ccm_grant,
   output logic      resolver_grant,
   output logic      ecb_grant,
   output logic      other_busy,
   output logic      preempt
);
   // ccm first, resolver second, block encryptor last
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ccm_grant      <= 1'b0;
         resolver_grant <= 1'b0;
         ecb_grant      <= 1'b0;
      end else begin
         ccm_grant      <= ccm_claim;
         resolver_grant <= resolver_claim && !ccm_claim;
         ecb_grant      <= ecb_req && !ccm_claim && !resolver_claim; // [R5] [R17]
      end
   end

   // any higher user holding or claiming the core
   assign other_busy = ccm_claim || resolver_claim || ccm_grant || resolver_grant;
   assign preempt    = ecb_req && (ccm_claim || resolver_claim); // [R5]

   property p_low_prio;
      @(posedge clock) disable iff (!resetn)
      ecb_grant |-> !ccm_grant && !resolver_grant && $past(ecb_req);
   endproperty
   a_low_prio: assert property (p_low_prio) else $error("encryptor granted beside a higher user"); // [R5]
endmodule : aesb_arbiter

// >>> core/aesb_cipher.sv
// aes-128 encrypt engine, one round per clock, words loaded by the controller
`timescale 1ns/1ps
`include "aesb_defines.svh"
module aesb_cipher import aesb_pkg::*; (
   input wire logic    clock,
   input wire logic    resetn,
   aesb_core_if.engine core
);
   aesb_cstate_t cstate;
   logic [127:0] key;
   logic [127:0] st;
   logic [7:0]   rcon;
   logic [3:0]   rnd;
   logic [2:0]   lcnt;
   logic [7:0]   sr [0:15];
   logic [127:0] sr_w;
   logic [127:0] mx_w;
   logic [31:0]  temp;
   logic [31:0]  nk0;
   logic [31:0]  nk1;
   logic [31:0]  nk2;
   logic [31:0]  nk3;
   logic [255:0] shifted;

   function automatic logic [7:0] xt(input logic [7:0] a);
      return {a[6:0], 1'b0} ^ (a[7] ? `AESB_GF_POLY : 8'h00);
   endfunction : xt

   function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] r;
      logic [7:0] p;
      r = 8'h00;
      p = a;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) r = r ^ p;
         p = xt(p);
      end
      return r;
   endfunction : gmul

   // inverse as x^254, then the affine map
   function automatic logic [7:0] sbox(input logic [7:0] x);
      logic [7:0] s;
      logic [7:0] v;
      s = x;
      v = 8'h01;
      for (int i = 0; i < 7; i++) begin
         s = gmul(s, s);
         v = gmul(v, s);
      end
      return v ^ {v[6:0], v[7]} ^ {v[5:0], v[7:6]} ^ {v[4:0], v[7:5]} ^ {v[3:0], v[7:4]} ^ `AESB_SBOX_AFF;
   endfunction : sbox

   // per byte: substitution, row shift and column mix
   for (genvar gi = 0; gi < 16; gi++) begin : g_byte
      localparam int C = gi / 4;
      localparam int R = gi % 4;
      assign sr[gi] = sbox(st[127 - 8 * (4 * ((C + R) % 4) + R) -: 8]);
      assign sr_w[127 - 8 * gi -: 8] = sr[gi];
      assign mx_w[127 - 8 * gi -: 8] = xt(sr[4 * C + R]) ^ xt(sr[4 * C + (R + 1) % 4]) ^ sr[4 * C + (R + 1) % 4]
                                       ^ sr[4 * C + (R + 2) % 4] ^ sr[4 * C + (R + 3) % 4];
   end

   // on-the-fly key schedule
   assign temp = {sbox(key[23:16]), sbox(key[15:8]), sbox(key[7:0]), sbox(key[31:24])} ^ {rcon, 24'h000000};
   assign nk0 = key[127:96] ^ temp;
   assign nk1 = key[95:64] ^ nk0;
   assign nk2 = key[63:32] ^ nk1;
   assign nk3 = key[31:0] ^ nk2;
   // little-endian memory word into the big-endian key and state chain
   assign shifted = {key[95:0], st, core.word[7:0], core.word[15:8], core.word[23:16], core.word[31:24]};
   assign core.result = st;
   assign core.busy   = (cstate == CS_RUN);

   // load eight words, whiten, then ten rounds
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cstate    <= CS_LOAD;
         key       <= '0;
         st        <= '0;
         rcon      <= `AESB_RCON_INIT;
         rnd       <= `AESB_ROUND_FIRST;
         lcnt      <= '0;
         core.done <= 1'b0;
      end else if (core.abort) begin
         cstate    <= CS_LOAD;
         lcnt      <= '0;
         core.done <= 1'b0;
      end else begin
         core.done <= 1'b0;
         unique case (cstate)
            CS_LOAD: if (core.load) begin
               lcnt <= lcnt + 3'h1;
               key  <= shifted[255:128];
               st   <= (lcnt == `AESB_FETCH_LAST) ? shifted[127:0] ^ shifted[255:128] : shifted[127:0];
               if (lcnt == `AESB_FETCH_LAST) begin
                  cstate <= CS_RUN; // [R2]
                  rcon   <= `AESB_RCON_INIT;
                  rnd    <= `AESB_ROUND_FIRST;
               end
            end
            CS_RUN: begin
               key  <= {nk0, nk1, nk2, nk3};
               rcon <= xt(rcon);
               rnd  <= rnd + 4'h1;
               st   <= ((rnd == `AESB_ROUNDS) ? sr_w : mx_w) ^ {nk0, nk1, nk2, nk3}; // [R1]
               if (rnd == `AESB_ROUNDS) begin
                  cstate    <= CS_LOAD;
                  core.done <= 1'b1;
               end
            end
         endcase
      end
   end

   sequence s_last_load;
      cstate == CS_LOAD && core.load && lcnt == `AESB_FETCH_LAST && !core.abort;
   endsequence
   property p_ten_rounds;
      @(posedge clock) disable iff (!resetn)
      s_last_load |-> ##11 (core.done || (cstate == CS_LOAD && lcnt == 3'h0));
   endproperty
   a_ten_rounds: assert property (p_ten_rounds) else $error("cipher did not end ten rounds after load"); // [R1]
   property p_done_ends_run;
      @(posedge clock) disable iff (!resetn)
      core.done |-> !core.busy && $past(core.busy) && $past(rnd) == `AESB_ROUNDS;
   endproperty
   a_done_ends_run: assert property (p_done_ends_run) else $error("done without a full run"); // [R1]
endmodule : aesb_cipher

// >>> bench/aesb_ram_model.sv
// behavioural data ram holding one block structure
`timescale 1ns/1ps
module aesb_ram_model #(
   parameter logic [31:0] BASE = 32'h2000_0100
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        req,
   input  wire logic        we,
   input  wire logic [31:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  lat,
   output logic             ack,
   output logic      [31:0] rdata
);
   logic [31:0] mem [0:11];
   logic [3:0]  wcnt;
   int          bad;
   wire  [31:0] idx = (addr - BASE) >> 2;
   // key words, cleartext words, empty ciphertext
   initial begin
      mem = '{32'h0302_0100, 32'h0706_0504, 32'h0b0a_0908, 32'h0f0e_0d0c,
              32'h3322_1100, 32'h7766_5544, 32'hbbaa_9988, 32'hffee_ddcc,
              32'h0, 32'h0, 32'h0, 32'h0};
      bad = 0;
   end
   // answer lat+1 cycles after the request; released data toggles every cycle
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ack   <= 1'b0;
         wcnt  <= 4'h0;
         rdata <= 32'h5a5a_5a5a;
      end else begin
         ack   <= 1'b0;
         rdata <= ~rdata;
         if (req && (addr < BASE || addr >= BASE + 32'h30))
            bad++;
         if (req && !ack && wcnt == lat) begin
            ack  <= 1'b1;
            wcnt <= 4'h0;
            if (we)
               mem[idx[3:0]] <= wdata;
            else
               rdata <= mem[idx[3:0]];
         end else if (req && !ack) begin
            wcnt <= wcnt + 4'h1;
         end
      end
   end
endmodule : aesb_ram_model

// >>> bench/aesb_top_tb.sv
// self-checking bench for the single-block encryptor
`timescale 1ns/1ps
module aesb_top_tb;
   localparam logic [31:0] PTR = 32'h2000_0100;
   localparam logic [31:0] CT [4] = '{32'hd8e0_c469, 32'h3004_7b6a, 32'h80b7_cdd8, 32'h5ac5_b470};
   logic        clock, resetn, reg_write, reg_read, ccm_claim, resolver_claim;
   logic        irq, dma_req, dma_we, dma_ack, ccm_grant, resolver_grant;
   logic [3:0]  lat;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, dma_addr, dma_wdata, dma_rdata, rd;
   int          err_total, n_compared, cyc, n_xfer;

   aesb_top aesb_top_i (
      .CLOCK(clock), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WRITE(reg_write), .REG_READ(reg_read), .REG_RDATA(reg_rdata), .IRQ(irq),
      .DMA_REQ(dma_req), .DMA_WE(dma_we), .DMA_ADDR(dma_addr), .DMA_WDATA(dma_wdata),
      .DMA_RDATA(dma_rdata), .DMA_ACK(dma_ack), .CCM_CLAIM(ccm_claim),
      .RESOLVER_CLAIM(resolver_claim), .CCM_GRANT(ccm_grant), .RESOLVER_GRANT(resolver_grant));
   aesb_ram_model aesb_ram_model_i (
      .clock(clock), .resetn(resetn), .req(dma_req), .we(dma_we), .addr(dma_addr),
      .wdata(dma_wdata), .lat(lat), .ack(dma_ack), .rdata(dma_rdata));

   // 40 MHz clock
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // cycle and transfer counters
   always @(posedge clock) begin
      cyc++;
      if (dma_req && dma_ack)
         n_xfer++;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd_reg(input logic [11:0] a);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 rd = reg_rdata;
   endtask : rd_reg
   // poll a flag with a bounded count
   task automatic wait_flag(input logic [11:0] a);
      int n;
      n  = 0;
      rd = 32'h0;
      while (rd[0] !== 1'b1 && n < 200) begin
         rd_reg(a);
         n++;
      end
      if (rd[0] !== 1'b1) begin
         err_total++;
         $display("MISMATCH flag %h expected 1 seen 0", a);
         test_done();
      end
   endtask : wait_flag

   task automatic t_regs;
      logic [11:0] a [7];
      a = '{12'h100, 12'h104, 12'h304, 12'h308, 12'h504, 12'h200, 12'h000};
      foreach (a[i]) begin
         rd_reg(a[i]);
         chk("reset value", 32'h0, rd);
      end
      wr(12'h304, 32'h3);
      rd_reg(12'h308);
      chk("enables", 32'h3, rd);
      wr(12'h308, 32'h1);
      rd_reg(12'h304);
      chk("enables", 32'h2, rd);
      wr(12'h104, 32'h1);
      #1 chk("irq", 32'h1, {31'h0, irq});
      wr(12'h308, 32'h2);
      #1 chk("irq", 32'h0, {31'h0, irq});
      wr(12'h104, 32'h0);
      wr(12'h200, 32'h1);
      rd_reg(12'h200);
      chk("unmapped", 32'h0, rd);
      $display("test regs done");
   endtask : t_regs

   task automatic t_enc;
      int t0, x0;
      wr(12'h304, 32'h1);
      for (int k = 0; k < 2; k++) begin
         for (int j = 8; j < 12; j++)
            aesb_ram_model_i.mem[j] = 32'h0;
         lat <= 4'(k * 3);
         wr(12'h504, PTR);
         x0 = n_xfer;
         wr(12'h000, 32'h1);
         t0 = cyc;
         wait_flag(12'h100);
         chk("block time", 32'h1, {31'h0, (cyc - t0) <= 288});
         chk("transfers", 32'd12, 32'(n_xfer - x0));
         chk("dma idle", 32'h0, {31'h0, dma_req});
         chk("irq", 32'h1, {31'h0, irq});
         for (int j = 0; j < 4; j++)
            chk("ciphertext", CT[j], aesb_ram_model_i.mem[8 + j]);
         wr(12'h100, 32'h0);
         #1 chk("irq", 32'h0, {31'h0, irq});
      end
      rd_reg(12'h104);
      chk("error flag", 32'h0, rd);
      wr(12'h308, 32'h1);
      $display("test encrypt done");
   endtask : t_enc

   task automatic t_abort;
      lat <= 4'h8;
      wr(12'h004, 32'h1);
      rd_reg(12'h104);
      chk("idle abort", 32'h0, rd);
      wr(12'h000, 32'h1);
      repeat (11) @(posedge clock); // abort lands in the gap between reads
      wr(12'h004, 32'h1);
      wait_flag(12'h104);
      chk("dma idle", 32'h0, {31'h0, dma_req});
      rd_reg(12'h100);
      chk("done after abort", 32'h0, rd);
      wr(12'h104, 32'h0);
      $display("test abort done");
   endtask : t_abort

   task automatic t_preempt;
      lat <= 4'h2;
      for (int k = 0; k < 2; k++) begin
         wr(12'h000, 32'h1);
         repeat (8 + 2 * k) @(posedge clock); // first claim meets a wait, second an ack
         ccm_claim      <= (k == 0);
         resolver_claim <= (k == 1);
         wait_flag(12'h104);
         chk("dma idle", 32'h0, {31'h0, dma_req});
         chk("grant", 32'(k == 0 ? 2 : 1), {30'h0, ccm_grant, resolver_grant});
         ccm_claim      <= 1'b0;
         resolver_claim <= 1'b0;
         wr(12'h104, 32'h0);
      end
      $display("test preempt done");
   endtask : t_preempt

   task automatic t_busy;
      int x0;
      logic [31:0] p [4];
      p = '{PTR, 32'h2000_7ff0, 32'h2000_0102, 32'h1000_0000};
      resolver_claim <= 1'b1;
      foreach (p[i]) begin
         if (i == 1)
            resolver_claim <= 1'b0;
         wr(12'h504, p[i]);
         x0 = n_xfer;
         wr(12'h000, 32'h1);
         wait_flag(12'h104);
         chk("no fetch", 32'h0, 32'(n_xfer - x0));
         wr(12'h104, 32'h0);
      end
      chk("stray dma", 32'h0, 32'(aesb_ram_model_i.bad));
      $display("test refused start done");
   endtask : t_busy

   initial begin
      resetn = 1'b0;
      {reg_write, reg_read, ccm_claim, resolver_claim} = 4'h0;
      reg_addr  = 12'h0;
      reg_wdata = 32'h0;
      lat       = 4'h0;
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      t_regs();
      t_enc();
      t_abort();
      t_preempt();
      t_busy();
      test_done();
   end
endmodule : aesb_top_tb
